// ==== logic/mbip_defines.svh ====
// Constants of the micro bus interrupt port
`ifndef MBIP_DEFINES_SVH
`define MBIP_DEFINES_SVH
`define MBIP_DATA_W 8
`define MBIP_ADDR_W 4
`define MBIP_NSRC 8
// Register locations, demultiplexed style: bank bit then address
`define MBIP_OMR_ADDR 4'hf
`define MBIP_ISR_ADDR 4'h0
`define MBIP_MASK_ADDR 4'h1
`define MBIP_EVT_ADDR 4'h2
`define MBIP_SCR0_ADDR 4'h0
`define MBIP_SCR1_ADDR 4'h1
// Operation mode register field
`define MBIP_RBS_BIT 0
// Reset values
`define MBIP_OMR_RST 8'h00
`define MBIP_MASK_RST 8'hff
`define MBIP_SCR_RST 8'h00
`endif

// ==== logic/mbip_pkg.sv ====
// Types of the micro bus interrupt port
package mbip_pkg;
  typedef enum logic [1:0] {
    MBIP_STROBE_DIR,
    MBIP_SEP_STROBE,
    MBIP_MUXED
  } mbip_style_t;
  typedef enum logic [1:0] {
    MBIP_ACC_RO,
    MBIP_ACC_WO,
    MBIP_ACC_RW,
    MBIP_ACC_NONE
  } mbip_acc_t;
endpackage : mbip_pkg

// ==== logic/mbip_style_det.sv ====
// Bus style detector driven by the address latch enable level
`timescale 1ns/1ns
`default_nettype none
`include "mbip_defines.svh"
module mbip_style_det
  import mbip_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_ale,
  output mbip_pkg::mbip_style_t o_style
);
  typedef struct packed {
    logic ale_q;
    logic seen;
    mbip_style_t style;
  } mbip_det_state_t;
  mbip_det_state_t st;
  mbip_det_state_t next_st;
  always_comb begin
    next_st = st;
    next_st.ale_q = i_ale;
    if (!st.seen) begin
      next_st.seen = 1'b1;
      next_st.style = i_ale ? MBIP_STROBE_DIR : MBIP_SEP_STROBE;
    end else if (i_ale != st.ale_q) begin
      next_st.style = MBIP_MUXED;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_style = (st.seen && i_ale != st.ale_q) ? MBIP_MUXED : st.style;
endmodule : mbip_style_det
`default_nettype wire

// ==== logic/mbip_port.sv ====
// Micro bus host port with register banks and interrupt signalling
`timescale 1ns/1ns
`default_nettype none
`include "mbip_defines.svh"
module mbip_port
  import mbip_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic [`MBIP_ADDR_W-1:0] i_addr,
  input wire logic [`MBIP_DATA_W-1:0] i_data,
  output logic [`MBIP_DATA_W-1:0] o_data,
  output logic o_data_oe,
  input wire logic i_cs_n,
  input wire logic i_ale,
  input wire logic i_rd_ds_n,
  input wire logic i_wr_rw_n,
  input wire logic [`MBIP_NSRC-1:0] i_src_evt,
  output logic o_int,
  output logic [`MBIP_DATA_W-1:0] o_setup0,
  output logic [`MBIP_DATA_W-1:0] o_setup1,
  output logic [`MBIP_DATA_W-1:0] o_mode
);
  // ----------------------------------------
  // Types and state
  // ----------------------------------------
  typedef enum {
    MBIP_IDLE,
    MBIP_ACCESS
  } mbip_ph_t;

  typedef enum {
    MBIP_T_NONE,
    MBIP_T_OMR,
    MBIP_T_ISR,
    MBIP_T_MASK,
    MBIP_T_CLR,
    MBIP_T_SCR0,
    MBIP_T_SCR1
  } mbip_tgt_t;

  typedef struct packed {
    mbip_ph_t ph;
    logic [`MBIP_ADDR_W:0] alat;
    logic [`MBIP_DATA_W-1:0] omr;
    logic [`MBIP_DATA_W-1:0] mask;
    logic [`MBIP_DATA_W-1:0] isr;
    logic [`MBIP_DATA_W-1:0] scr0;
    logic [`MBIP_DATA_W-1:0] scr1;
    logic [`MBIP_DATA_W-1:0] dout;
    logic doe;
    logic irq;
  } mbip_state_t;

  mbip_state_t st;
  mbip_state_t next_st;
  mbip_style_t style;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic [4:0] mbip_loc(input mbip_style_t sty,
                                          input logic [`MBIP_ADDR_W-1:0] a,
                                          input logic [`MBIP_ADDR_W:0] al,
                                          input logic bank);
    logic [`MBIP_ADDR_W-1:0] eff;
    eff = a;
    if (sty == MBIP_MUXED) begin
      eff = al[`MBIP_ADDR_W:1];
    end
    if (eff == `MBIP_OMR_ADDR) begin
      mbip_loc = {1'b0, eff};
    end else begin
      mbip_loc = {bank, eff};
    end
  endfunction : mbip_loc

  // ----------------------------------------
  // Target decode
  // ----------------------------------------
  function automatic mbip_tgt_t mbip_tgt(input logic [4:0] loc, input logic odd);
    mbip_tgt = MBIP_T_NONE;
    if (odd) begin
      mbip_tgt = MBIP_T_NONE;
    end else if (loc[3:0] == `MBIP_OMR_ADDR) begin
      mbip_tgt = MBIP_T_OMR;
    end else if (!loc[4]) begin
      case (loc[3:0])
        `MBIP_ISR_ADDR: begin
          mbip_tgt = MBIP_T_ISR;
        end
        `MBIP_MASK_ADDR: begin
          mbip_tgt = MBIP_T_MASK;
        end
        `MBIP_EVT_ADDR: begin
          mbip_tgt = MBIP_T_CLR;
        end
        default: begin
          mbip_tgt = MBIP_T_NONE;
        end
      endcase
    end else begin
      case (loc[3:0])
        `MBIP_SCR0_ADDR: begin
          mbip_tgt = MBIP_T_SCR0;
        end
        `MBIP_SCR1_ADDR: begin
          mbip_tgt = MBIP_T_SCR1;
        end
        default: begin
          mbip_tgt = MBIP_T_NONE;
        end
      endcase
    end
  endfunction : mbip_tgt

  // ----------------------------------------
  // Access rights
  // ----------------------------------------
  function automatic mbip_acc_t mbip_acc(input mbip_tgt_t tgt);
    case (tgt)
      MBIP_T_OMR, MBIP_T_MASK, MBIP_T_SCR0, MBIP_T_SCR1: begin
        mbip_acc = MBIP_ACC_RW;
      end
      MBIP_T_ISR: begin
        mbip_acc = MBIP_ACC_RO;
      end
      MBIP_T_CLR: begin
        mbip_acc = MBIP_ACC_WO;
      end
      default: begin
        mbip_acc = MBIP_ACC_NONE;
      end
    endcase
  endfunction : mbip_acc

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  function automatic logic [`MBIP_DATA_W-1:0] mbip_rdval(input mbip_tgt_t tgt,
                                                        input mbip_state_t s);
    case (tgt)
      MBIP_T_OMR: begin
        mbip_rdval = s.omr;
      end
      MBIP_T_ISR: begin
        mbip_rdval = s.isr;
      end
      MBIP_T_MASK: begin
        mbip_rdval = s.mask;
      end
      MBIP_T_SCR0: begin
        mbip_rdval = s.scr0;
      end
      MBIP_T_SCR1: begin
        mbip_rdval = s.scr1;
      end
      default: begin
        mbip_rdval = '0;
      end
    endcase
  endfunction : mbip_rdval

  // ----------------------------------------
  // Strobe decode
  // ----------------------------------------
  function automatic logic [1:0] mbip_strobe(input mbip_style_t sty,
                                             input logic cs_n,
                                             input logic rd_ds_n,
                                             input logic wr_rw_n);
    mbip_strobe = 2'b00;
    if (!cs_n) begin
      if (sty == MBIP_STROBE_DIR) begin
        mbip_strobe = {!rd_ds_n && wr_rw_n, !rd_ds_n && !wr_rw_n};
      end else begin
        mbip_strobe = {!rd_ds_n && wr_rw_n, !wr_rw_n && rd_ds_n};
      end
    end
  endfunction : mbip_strobe

  // ----------------------------------------
  // Bus style
  // ----------------------------------------
  mbip_style_det u_style (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_ale(i_ale),
    .o_style(style)
  );

  // ----------------------------------------
  // Access and interrupt logic
  // ----------------------------------------
  logic rd_req;
  logic wr_req;
  logic odd;
  logic [4:0] loc;
  mbip_acc_t acc;
  mbip_tgt_t tgt;
  logic mask_wr;
  logic [`MBIP_DATA_W-1:0] pend;
  logic [1:0] rw;

  always_comb begin
    next_st = st;
    rd_req = 1'b0;
    wr_req = 1'b0;
    odd = 1'b0;
    // ----------------------------------------
    // Address phase
    // ----------------------------------------
    if (style == MBIP_MUXED && i_ale) begin
      next_st.alat = i_data[`MBIP_ADDR_W:0];
    end
    odd = (style == MBIP_MUXED) && st.alat[0];
    loc = mbip_loc(style, i_addr, st.alat, st.omr[`MBIP_RBS_BIT]);
    tgt = mbip_tgt(loc, odd);
    acc = mbip_acc(tgt);
    // ----------------------------------------
    // Strobes
    // ----------------------------------------
    rw = mbip_strobe(style, i_cs_n, i_rd_ds_n, i_wr_rw_n);
    rd_req = rw[1];
    wr_req = rw[0];
    mask_wr = wr_req && tgt == MBIP_T_MASK;
    next_st.ph = (rd_req || wr_req) ? MBIP_ACCESS : MBIP_IDLE;
    // ----------------------------------------
    // Status: events set, write-one clears, set wins
    // ----------------------------------------
    next_st.isr = st.isr & ~(wr_req && tgt == MBIP_T_CLR ? i_data : '0);
    next_st.isr = next_st.isr | i_src_evt;
    next_st.isr = next_st.isr & ~st.mask;
    // ----------------------------------------
    // Register writes, once per access
    // ----------------------------------------
    if (wr_req && st.ph == MBIP_IDLE) begin
      case (tgt)
        MBIP_T_OMR: begin
          next_st.omr = i_data;
        end
        MBIP_T_MASK: begin
          next_st.mask = i_data;
        end
        MBIP_T_SCR0: begin
          next_st.scr0 = i_data;
        end
        MBIP_T_SCR1: begin
          next_st.scr1 = i_data;
        end
        default: begin
        end
      endcase
    end
    // ----------------------------------------
    // Read data and interrupt
    // ----------------------------------------
    next_st.doe = rd_req && (acc == MBIP_ACC_RO || acc == MBIP_ACC_RW);
    next_st.dout = mbip_rdval(tgt, st);
    pend = next_st.isr;
    next_st.irq = (|pend) && !mask_wr;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      st.ph <= MBIP_IDLE;
      st.alat <= '0;
      st.omr <= `MBIP_OMR_RST;
      st.mask <= `MBIP_MASK_RST;
      st.isr <= '0;
      st.scr0 <= `MBIP_SCR_RST;
      st.scr1 <= `MBIP_SCR_RST;
      st.dout <= '0;
      st.doe <= 1'b0;
      st.irq <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_data = st.dout;
  assign o_data_oe = st.doe;
  assign o_int = st.irq;
  assign o_setup0 = st.scr0;
  assign o_setup1 = st.scr1;
  assign o_mode = st.omr;
endmodule : mbip_port
`default_nettype wire

// ==== test/mbip_port_properties.sv ====
// Checker of the micro bus interrupt port
`timescale 1ns/1ns
`default_nettype none
`include "mbip_defines.svh"
module mbip_port_properties (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_data,
  input wire logic [7:0] o_data,
  input wire logic o_data_oe,
  input wire logic i_cs_n,
  input wire logic i_ale,
  input wire logic i_rd_ds_n,
  input wire logic i_wr_rw_n,
  input wire logic o_int,
  input wire logic [7:0] o_setup0,
  input wire logic [7:0] o_mode
);
  logic muxed, wr_q, sep, bank, wr, wgo, rgo;
  always_ff @(posedge i_sys_clk) begin
    muxed <= !i_srst && (muxed || $changed(i_ale));
    wr_q <= i_wr_rw_n;
  end
  assign sep = !muxed && !i_ale && !i_cs_n;
  assign bank = o_mode[`MBIP_RBS_BIT];
  assign wr = sep && !i_wr_rw_n && i_rd_ds_n;
  assign wgo = wr && wr_q;
  assign rgo = sep && !i_rd_ds_n && i_wr_rw_n;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  sequence s_mask_wr;
    wr && i_addr == `MBIP_MASK_ADDR && !bank ##1 wr;
  endsequence
  sequence s_mode_rd;
    rgo && i_addr == `MBIP_OMR_ADDR ##1 rgo [*2];
  endsequence
  AST_RST: assert property (disable iff (1'b0) i_srst |=> !o_int && o_mode == 8'h00)
    else $error("reset state wrong");
  AST_INT_OFF: assert property (s_mask_wr |-> !o_int)
    else $error("int high in mask write");
  AST_RD_MODE: assert property (s_mode_rd |-> o_data_oe && o_data == o_mode)
    else $error("mode read wrong");
  AST_MODE_WR: assert property (wgo && i_addr == `MBIP_OMR_ADDR |=> o_mode == $past(i_data))
    else $error("mode write lost");
  AST_SETUP_WR: assert property (wgo && i_addr == 4'h0 && bank |=> o_setup0 == $past(i_data))
    else $error("setup write lost");
  AST_BANK0: assert property (wgo && i_addr == 4'h0 && !bank |=> $stable(o_setup0))
    else $error("setup hit in bank 0");
  AST_MODE_CS: assert property (i_cs_n |=> $stable(o_mode))
    else $error("mode changed unselected");
  AST_OE_CS: assert property (i_cs_n && $past(i_cs_n) |-> !o_data_oe)
    else $error("bus driven unselected");
  AST_OE_DROP: assert property (i_rd_ds_n && $past(i_rd_ds_n) |-> !o_data_oe)
    else $error("bus driven without read");
endmodule : mbip_port_properties
bind mbip_port mbip_port_properties mbip_port_properties_inst (.i_sys_clk(i_sys_clk),
  .i_srst(i_srst), .i_addr(i_addr), .i_data(i_data), .o_data(o_data), .o_data_oe(o_data_oe),
  .i_cs_n(i_cs_n), .i_ale(i_ale), .i_rd_ds_n(i_rd_ds_n), .i_wr_rw_n(i_wr_rw_n),
  .o_int(o_int), .o_setup0(o_setup0), .o_mode(o_mode));
`default_nettype wire

// ==== test/mbip_host_model.sv ====
// Host processor model on the split strobe, data strobe or multiplexed bus
`timescale 1ns/1ns
`default_nettype none
module mbip_host_model (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_bus,
  output logic [3:0] o_addr,
  output logic [7:0] o_data,
  output logic o_cs_n,
  output logic o_ale,
  output logic o_rd_n,
  output logic o_wr_n
);
  logic ds_mode = 1'b0;
  initial begin
    {o_addr, o_data, o_cs_n, o_ale, o_rd_n, o_wr_n} = {12'h000, 4'hb};
  end
  // One access, entered just after an edge
  task acc(input logic cs, input logic w, input logic [3:0] a, input logic [7:0] d,
    output logic [7:0] q);
    o_cs_n = !cs;
    o_addr = a;
    o_data = w ? d : ~o_data;
    o_wr_n = !w;
    o_rd_n = ds_mode ? 1'b0 : w;
    repeat (3) @(posedge i_sys_clk);
    q = i_bus;
    #1;
    {o_cs_n, o_rd_n, o_wr_n} = 3'h7;
    o_data = ~o_data;
    o_addr = ~o_addr;
    @(posedge i_sys_clk);
    #1;
  endtask : acc
  // Latch enable level and data strobe style
  task set_bus(input logic ale, input logic ds);
    o_ale = ale;
    ds_mode = ds;
  endtask : set_bus
  // Muxed access: address byte on the data lines while latch enable is high
  task acc_mux(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    o_ale = 1'b1;
    o_data = a;
    @(posedge i_sys_clk);
    #1;
    o_ale = 1'b0;
    acc(1'b1, w, 4'h0, d, q);
  endtask : acc_mux
endmodule : mbip_host_model
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench of the micro bus interrupt port
`timescale 1ns/1ns
`default_nettype none
`include "mbip_defines.svh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench;
  logic i_sys_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] evt = 8'h00;
  logic [3:0] addr;
  logic [7:0] hdata, dout, bus, s0, s1, mode, q;
  logic cs_n, ale, rd_n, wr_n, oe, int_o;
  int failures = 0;
  int cmp_count = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  assign bus = oe ? dout : hdata;
  mbip_host_model mbip_host_model_inst (.i_sys_clk(i_sys_clk), .i_bus(bus), .o_addr(addr),
    .o_data(hdata), .o_cs_n(cs_n), .o_ale(ale), .o_rd_n(rd_n), .o_wr_n(wr_n));
  mbip_port mbip_port_inst (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(addr),
    .i_data(bus), .o_data(dout), .o_data_oe(oe), .i_cs_n(cs_n), .i_ale(ale),
    .i_rd_ds_n(rd_n), .i_wr_rw_n(wr_n), .i_src_evt(evt), .o_int(int_o),
    .o_setup0(s0), .o_setup1(s1), .o_mode(mode));
  task stop_test;
    $display("failures %0d cmp_count %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task wr(input logic [3:0] a, input logic [7:0] d);
    mbip_host_model_inst.acc(1'b1, 1'b1, a, d, q);
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] e);
    mbip_host_model_inst.acc(1'b1, 1'b0, a, 8'h00, q);
    `CHK("read", e, q)
  endtask : rd
  task tick(input int n, input logic [7:0] v);
    evt = v;
    @(posedge i_sys_clk);
    #1 evt = 8'h00;
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : tick
  task t_reset;
    `CHK("setup0", `MBIP_SCR_RST, s0)
    rd(`MBIP_MASK_ADDR, `MBIP_MASK_RST);
    rd(`MBIP_ISR_ADDR, 8'h00);
  endtask : t_reset
  task t_bank;
    wr(`MBIP_OMR_ADDR, 8'h01);
    wr(`MBIP_SCR0_ADDR, 8'ha5);
    wr(`MBIP_SCR1_ADDR, 8'h5a);
    `CHK("setup1", 8'h5a, s1)
    rd(`MBIP_OMR_ADDR, 8'h01);
    rd(`MBIP_SCR1_ADDR, 8'h5a);
    wr(`MBIP_OMR_ADDR, 8'h00);
    rd(`MBIP_OMR_ADDR, 8'h00);
    wr(`MBIP_ISR_ADDR, 8'h3c);
    `CHK("setup0", 8'ha5, s0)
  endtask : t_bank
  task t_int;
    wr(`MBIP_MASK_ADDR, 8'h00);
    tick(2, 8'h04);
    `CHK("int", 1'b1, int_o)
    rd(`MBIP_ISR_ADDR, 8'h04);
    tick(0, 8'h10);
    for (int i = 0; i < 4; i++) begin
      tick(0, 8'h00);
      `CHK("int", 1'b1, int_o)
    end
    wr(`MBIP_EVT_ADDR, 8'h04);
    `CHK("int", 1'b1, int_o)
    wr(`MBIP_MASK_ADDR, 8'h00);
    tick(0, 8'h00);
    `CHK("int", 1'b1, int_o)
    wr(`MBIP_EVT_ADDR, 8'h10);
    tick(0, 8'h00);
    `CHK("int", 1'b0, int_o)
    wr(`MBIP_MASK_ADDR, 8'hfe);
    tick(2, 8'h02);
    `CHK("int", 1'b0, int_o)
    rd(`MBIP_ISR_ADDR, 8'h00);
    tick(2, 8'h01);
    `CHK("int", 1'b1, int_o)
  endtask : t_int
  task t_cs;
    mbip_host_model_inst.acc(1'b0, 1'b1, `MBIP_OMR_ADDR, 8'hff, q);
    `CHK("mode", 8'h00, mode)
  endtask : t_cs
  task t_mux;
    mbip_host_model_inst.acc_mux(1'b1, 8'h1e, 8'h01, q);
    `CHK("mode", 8'h01, mode)
    mbip_host_model_inst.acc_mux(1'b1, 8'h00, 8'h77, q);
    `CHK("setup0", 8'h77, s0)
    mbip_host_model_inst.acc_mux(1'b0, 8'h1e, 8'h00, q);
    `CHK("read", 8'h01, q)
    mbip_host_model_inst.acc_mux(1'b1, 8'h01, 8'h33, q);
    `CHK("setup0", 8'h77, s0)
    wr(`MBIP_SCR0_ADDR, 8'h99);
    `CHK("setup0", 8'h77, s0)
  endtask : t_mux
  task t_strobe;
    i_srst = 1'b1;
    @(posedge i_sys_clk);
    #1;
    mbip_host_model_inst.set_bus(1'b1, 1'b1);
    repeat (4) @(posedge i_sys_clk);
    #1 i_srst = 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1;
    `CHK("mode", 8'h00, mode)
    wr(`MBIP_OMR_ADDR, 8'h01);
    `CHK("mode", 8'h01, mode)
    wr(`MBIP_SCR1_ADDR, 8'hc3);
    rd(`MBIP_SCR1_ADDR, 8'hc3);
    mbip_host_model_inst.acc(1'b0, 1'b1, `MBIP_SCR1_ADDR, 8'h3c, q);
    `CHK("setup1", 8'hc3, s1)
  endtask : t_strobe
  initial begin
    repeat (12) @(posedge i_sys_clk);
    #1 i_srst = 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1;
    t_reset();
    t_bank();
    t_int();
    t_cs();
    t_mux();
    t_strobe();
    stop_test();
  end
  initial begin
    repeat (3000) @(posedge i_sys_clk);
    failures++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
